// file: hw/cbg_consts.svh
// Constants for the codec bit clock generator.
// Assumes one 10 MHz core clock and a byte register address.
`ifndef CBG_CONSTS_SVH
`define CBG_CONSTS_SVH
`define CBG_DIV_ADDR 8'h72
`define CBG_SRC_ADDR 8'h73
`define CBG_DIV_RST 16'h0000
`define CBG_SRC_RST 16'h0000
`define CBG_SRC_MASK 16'h30F0
`define CBG_B_PRE_EN 15
`define CBG_B_DEC_EN 14
`define CBG_B_ENC_EN 13
`define CBG_B_PD_STB 13
`define CBG_B_PD_DATA 12
`define CBG_B_PLL_EN 7
`define CBG_B_DEC_SEL 6
`define CBG_B_ENC_SRC 5
`define CBG_B_ENC_INT 4
// Divide ratios in eighths, code 7 first
`define CBG_FILT_TAB {9'h176, 9'h0FA, 9'h0B0, 9'h080, 9'h07E, 9'h07C, 9'h040, 9'h010}
`define CBG_BIT_TAB {9'h01C, 9'h01B, 9'h019, 9'h018, 9'h015, 9'h012, 9'h010, 9'h008}
`define CBG_FRAC_STEP 9'h008
`define CBG_POST_DIV_W 6
`define CBG_PLL_ADV 6'h03
`define CBG_PLL_RET 6'h3F
`define CBG_PLL_NOM 6'h01
`endif

// file: hw/cbg_pkg.sv
// Types for the codec bit clock generator.
// Assumes the constants header is included alongside.
package cbg_pkg;
    // Encoder bit clock source choices
    typedef enum logic [2:0] {
        CBG_ENC_PIN = 3'b001,
        CBG_ENC_GEN = 3'b010,
        CBG_ENC_DEC = 3'b100
    } cbg_enc_src_e;
    typedef logic [8:0] cbg_ratio_t;
    typedef logic [15:0] cbg_word_t;
endpackage

// file: hw/cbg_top.sv
// Clock dividers and selectors for the codec filter and bit clocks.
// Assumes pins and register strobes synchronous to core_clk_i.
`timescale 1ns/1ns
`include "cbg_consts.svh"
module cbg_top
    import cbg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Link pins
    input wire logic rx_clk_i,
    input wire logic rx_strobe_i,
    input wire logic rx_data_i,
    input wire logic tx_clk_i,
    // Clock outputs
    output logic filt_tick_o,
    output logic dec_rate_tick_o,
    output logic enc_rate_tick_o,
    output logic dec_bclk_o,
    output logic enc_bclk_o
);

    localparam cbg_ratio_t [7:0] FILT_TAB = `CBG_FILT_TAB;
    localparam cbg_ratio_t [7:0] BIT_TAB = `CBG_BIT_TAB;

    cbg_word_t div_q;
    cbg_word_t src_q;
    cbg_word_t rdata_q;

    // Register decode
    wire logic div_hit = (reg_addr_i == `CBG_DIV_ADDR);
    wire logic src_hit = (reg_addr_i == `CBG_SRC_ADDR);
    cbg_word_t rd_mux;
    assign rd_mux = div_hit ? div_q : (src_hit ? src_q : 16'h0000);

    // Register writes and read data
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            div_q <= `CBG_DIV_RST;
            src_q <= `CBG_SRC_RST;
            rdata_q <= 16'h0000;
        end else begin
            if (reg_wr_i && div_hit) begin
                div_q <= reg_wdata_i;
            end
            if (reg_wr_i && src_hit) begin
                src_q <= reg_wdata_i & `CBG_SRC_MASK; // Reserved read zero
            end
            if (reg_rd_i) begin
                rdata_q <= rd_mux;
            end
        end
    end
    assign reg_rdata_o = rdata_q;

    // Control fields
    wire logic pre_en = div_q[`CBG_B_PRE_EN];
    wire logic dec_en = div_q[`CBG_B_DEC_EN];
    wire logic enc_en = div_q[`CBG_B_ENC_EN];
    wire logic pll_en = src_q[`CBG_B_PLL_EN];
    wire logic dec_sel = src_q[`CBG_B_DEC_SEL];
    wire logic pd_stb = src_q[`CBG_B_PD_STB];
    wire logic pd_data = src_q[`CBG_B_PD_DATA];
    cbg_enc_src_e enc_src;
    assign enc_src = !src_q[`CBG_B_ENC_INT] ? CBG_ENC_PIN :
        (src_q[`CBG_B_ENC_SRC] ? CBG_ENC_DEC : CBG_ENC_GEN);

    // Prescale codes; disabled stage divides by one
    logic [1:0] pre_code [2];
    assign pre_code[0] = pre_en ? div_q[12:11] : 2'h0;
    assign pre_code[1] = pre_en ? div_q[7:6] : 2'h0;

    // Two prescalers: filter path and shared bit path
    logic [1:0] pre_cnt_q [2];
    logic pre_tick [2];
    genvar p;
    generate
        for (p = 0; p < 2; p++) begin : g_pre
            assign pre_tick[p] = (pre_cnt_q[p] >= pre_code[p]);
            always_ff @(posedge core_clk_i) begin
                if (srst_i || pre_tick[p]) begin
                    pre_cnt_q[p] <= 2'h0;
                end else begin
                    pre_cnt_q[p] <= pre_cnt_q[p] + 2'h1;
                end
            end
        end
    endgenerate

    // Fractional dividers: 0 filter, 1 decoder, 2 encoder
    cbg_ratio_t frac_num [3];
    logic frac_in [3];
    logic frac_run [3];
    assign frac_num[0] = FILT_TAB[div_q[10:8]];
    assign frac_num[1] = BIT_TAB[div_q[5:3]];
    assign frac_num[2] = BIT_TAB[div_q[2:0]];
    assign frac_in[0] = pre_tick[0];
    assign frac_in[1] = pre_tick[1];
    assign frac_in[2] = pre_tick[1];
    assign frac_run[0] = 1'b1;
    assign frac_run[1] = dec_en;
    assign frac_run[2] = enc_en;

    cbg_ratio_t acc_q [3];
    cbg_ratio_t acc_sum [3];
    cbg_ratio_t acc_rem [3];
    logic frac_tick [3];
    logic frac_tick_q [3];
    genvar f;
    generate
        for (f = 0; f < 3; f++) begin : g_frac
            // Accumulate eighths; each period is the floor or the ceil of the ratio
            assign acc_sum[f] = acc_q[f] + `CBG_FRAC_STEP;
            assign frac_tick[f] = frac_in[f] && (acc_sum[f] >= frac_num[f]);
            // Remainder after a tick; a ratio cut to a smaller value could leave it above the new ratio
            assign acc_rem[f] = acc_sum[f] - frac_num[f];
            always_ff @(posedge core_clk_i) begin
                if (srst_i || !frac_run[f]) begin
                    acc_q[f] <= 9'h000;
                    frac_tick_q[f] <= 1'b0;
                end else begin
                    frac_tick_q[f] <= frac_tick[f];
                    if (frac_tick[f]) begin
                        // Restart from zero so that no burst of ticks follows a ratio change
                        acc_q[f] <= (acc_rem[f] >= frac_num[f]) ? 9'h000 : acc_rem[f];
                    end else if (frac_in[f]) begin
                        acc_q[f] <= acc_sum[f];
                    end
                end
            end
        end
    endgenerate

    // Loop reference: clock or strobe, or data edges
    logic rx_clk_q;
    logic rx_stb_q;
    logic rx_dat_q;
    wire logic clk_rise = rx_clk_i && !rx_clk_q;
    wire logic stb_rise = rx_strobe_i && !rx_stb_q;
    wire logic dat_edge = rx_data_i ^ rx_dat_q;
    wire logic ref_edge = pd_data ? dat_edge : (pd_stb ? stb_rise : clk_rise);
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            rx_clk_q <= 1'b0;
            rx_stb_q <= 1'b0;
            rx_dat_q <= 1'b0;
        end else begin
            rx_clk_q <= rx_clk_i;
            rx_stb_q <= rx_strobe_i;
            rx_dat_q <= rx_data_i;
        end
    end

    // Post dividers by 64: 0 decoder, 1 encoder
    logic [5:0] post_q [2];
    logic post_run [2];
    logic post_in [2];
    assign post_run[0] = dec_en;
    assign post_run[1] = enc_en;
    assign post_in[0] = frac_tick[1];
    assign post_in[1] = frac_tick[2];

    // Pending loop correction for the decoder
    logic adv_q;
    logic ret_q;
    wire logic [5:0] dec_ph = post_q[0];
    wire logic ph_late = (dec_ph != 6'h00) && !dec_ph[5];
    wire logic ph_early = dec_ph[5];
    logic [5:0] dec_step;
    assign dec_step = !pll_en ? `CBG_PLL_NOM :
        (adv_q ? `CBG_PLL_ADV : (ret_q ? `CBG_PLL_RET : `CBG_PLL_NOM));
    logic [5:0] post_step [2];
    assign post_step[0] = dec_step;
    assign post_step[1] = `CBG_PLL_NOM;

    // Phase detector: one 1/32 step per reference edge
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !pll_en || !dec_en) begin
            adv_q <= 1'b0;
            ret_q <= 1'b0;
        end else if (ref_edge) begin
            adv_q <= ph_early;
            ret_q <= ph_late;
        end else if (post_in[0]) begin
            adv_q <= 1'b0;
            ret_q <= 1'b0;
        end
    end

    genvar c;
    generate
        for (c = 0; c < 2; c++) begin : g_post
            always_ff @(posedge core_clk_i) begin
                if (srst_i || !post_run[c]) begin
                    post_q[c] <= 6'h00;
                end else if (post_in[c]) begin
                    post_q[c] <= post_q[c] + post_step[c];
                end
            end
        end
    endgenerate

    // Internal bit clocks: high in the first half period
    wire logic dec_int = post_run[0] && !post_q[0][5];
    wire logic enc_int = post_run[1] && !post_q[1][5];

    // Source selection, gated by the enables
    logic dec_sel_clk;
    logic enc_sel_clk;
    assign dec_sel_clk = dec_en && (dec_sel ? dec_int : rx_clk_i);
    always_comb begin
        case (enc_src)
            CBG_ENC_GEN: enc_sel_clk = enc_int;
            CBG_ENC_DEC: enc_sel_clk = dec_sel_clk;
            default: enc_sel_clk = tx_clk_i;
        endcase
    end

    // Registered outputs
    logic filt_q;
    logic dec_tk_q;
    logic enc_tk_q;
    logic dec_bclk_q;
    logic enc_bclk_q;
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            filt_q <= 1'b0;
            dec_tk_q <= 1'b0;
            enc_tk_q <= 1'b0;
            dec_bclk_q <= 1'b0;
            enc_bclk_q <= 1'b0;
        end else begin
            filt_q <= frac_tick_q[0];
            dec_tk_q <= frac_tick_q[1];
            enc_tk_q <= frac_tick_q[2];
            dec_bclk_q <= dec_sel_clk;
            enc_bclk_q <= enc_en && enc_sel_clk;
        end
    end
    assign filt_tick_o = filt_q;
    assign dec_rate_tick_o = dec_tk_q;
    assign enc_rate_tick_o = enc_tk_q;
    assign dec_bclk_o = dec_bclk_q;
    assign enc_bclk_o = enc_bclk_q;

endmodule

// file: bench/cbg_top_assertions.sv
// Checker for the codec bit clock generator ports.
// Bound to cbg_top; shadows both registers from the write strobes.
`timescale 1ns/1ns
`include "cbg_consts.svh"
module cbg_top_assertions
    import cbg_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // Pins and clocks
    input wire logic rx_clk_i,
    input wire logic tx_clk_i,
    input wire logic filt_tick_o,
    input wire logic dec_rate_tick_o,
    input wire logic dec_bclk_o,
    input wire logic enc_bclk_o
);
    cbg_word_t div_q;
    cbg_word_t src_q;
    // Expected read value for the current address
    wire cbg_word_t rd_exp = reg_addr_i == `CBG_DIV_ADDR ? div_q :
        reg_addr_i == `CBG_SRC_ADDR ? src_q : 16'h0000;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    // Shadow copies of the registers
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            div_q <= 16'h0000;
            src_q <= 16'h0000;
        end else if (reg_wr_i && reg_addr_i == `CBG_DIV_ADDR) begin
            div_q <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == `CBG_SRC_ADDR) begin
            src_q <= reg_wdata_i & 16'h30F0;
        end
    end
    a_read_data: assert property (reg_rd_i |=> reg_rdata_o == $past(rd_exp))
        else $error("read data wrong");
    a_dec_off: assert property (!div_q[14] [*3] |-> !dec_bclk_o)
        else $error("decoder clock not stopped");
    a_enc_off: assert property (!div_q[13] [*3] |-> !enc_bclk_o)
        else $error("encoder clock not stopped");
    a_tx_pin: assert property ((div_q[13] && !src_q[4]) [*3] |-> enc_bclk_o == $past(tx_clk_i))
        else $error("encoder clock not from pin");
    a_rx_pin: assert property ((div_q[14] && !src_q[6]) [*3] |-> dec_bclk_o == $past(rx_clk_i))
        else $error("decoder clock not from pin");
    a_filt_gap: assert property (filt_tick_o |=> !filt_tick_o)
        else $error("filter ticks too close");
    a_rate_full: assert property ((div_q == 16'hE000) [*4] |-> dec_rate_tick_o)
        else $error("rate tick missing");
    a_half_64: assert property ($fell(dec_bclk_o) && div_q == 16'hE000 && src_q[7:6] == 2'b01
        && $past(div_q, 40) == 16'hE000 && $past(src_q[7:6], 40) == 2'b01
        |-> $past(dec_bclk_o, 32) && !$past(dec_bclk_o, 33))
        else $error("bit clock high half wrong");
endmodule
bind cbg_top cbg_top_assertions chk (.*);

// file: bench/cbg_link_model.sv
// Link partner: bit clock, strobe and data pins.
// Assumes the core clock; clocks stand low while not running.
`timescale 1ns/1ns
module cbg_link_model (
    // Clock and control
    input wire logic core_clk_i,
    input wire logic run_i,
    input wire logic [7:0] per_i,
    // Link pins
    output logic clk_o = 1'b0,
    output logic stb_o = 1'b0,
    output logic dat_o = 1'b0
);
    logic [7:0] cnt_q = 8'h00;
    // Period counter; idle data toggles every cycle
    always_ff @(posedge core_clk_i) begin
        cnt_q <= (!run_i || cnt_q == per_i - 8'h01) ? 8'h00 : cnt_q + 8'h01;
        clk_o <= run_i && cnt_q < per_i / 2;
        stb_o <= run_i && cnt_q == 8'h00;
        dat_o <= dat_o ^ (!run_i || cnt_q == 8'h00);
    end
endmodule

// file: bench/test_codec_bit_clock_generator.sv
// Bench for the clock generator: register access, rates and sources.
// Assumes cbg_top, its checker and the link model are compiled first.
`timescale 1ns/1ns
`include "cbg_consts.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED %s exp %0d got %0d", n, e, a); end end
module test_codec_bit_clock_generator;
    import cbg_pkg::*;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0;
    logic [7:0] addr = 8'h00, per = 8'h10;
    cbg_word_t wdata = 16'h0000, rdata;
    logic lc, ls, ld, ft, dt, et, db, eb;
    int n_errors = 0, samples_checked = 0, nf, nd, ne, rdc, rec, k;
    int btab[8] = '{8, 16, 18, 21, 24, 25, 27, 28};
    int ftab[8] = '{16, 64, 124, 126, 128, 176, 250, 374};
    cbg_word_t lsrc[3] = '{16'h00C0, 16'h20C0, 16'h10C0};
    always #50 clk = ~clk;
    cbg_top uut (.core_clk_i(clk), .srst_i(srst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_clk_i(lc), .rx_strobe_i(ls),
        .rx_data_i(ld), .tx_clk_i(lc), .filt_tick_o(ft), .dec_rate_tick_o(dt),
        .enc_rate_tick_o(et), .dec_bclk_o(db), .enc_bclk_o(eb));
    cbg_link_model link (.core_clk_i(clk), .run_i(run), .per_i(per), .clk_o(lc), .stb_o(ls), .dat_o(ld));
    function automatic bit near(int c, int e);
        return c >= e - 1 && c <= e + 1;
    endfunction
    task automatic conclude();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic wreg(input logic [7:0] a, input cbg_word_t d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input cbg_word_t e);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        `CHK("rdata", e, rdata)
    endtask
    // Program both registers, settle, then count ticks and rising edges
    task automatic meas(input cbg_word_t d, input cbg_word_t s, input int n);
        logic pd, pe;
        wreg(`CBG_DIV_ADDR, d);
        wreg(`CBG_SRC_ADDR, s);
        repeat (640) @(negedge clk);
        {nf, nd, ne, rdc, rec} = '0;
        pd = db;
        pe = eb;
        repeat (n) begin
            @(negedge clk);
            nf += ft;
            nd += dt;
            ne += et;
            rdc += db & !pd;
            rec += eb & !pe;
            pd = db;
            pe = eb;
        end
    endtask
    initial begin
        #(80000 * 100);
        n_errors++;
        conclude();
    end
    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        rreg(`CBG_DIV_ADDR, 16'h0000);
        rreg(`CBG_SRC_ADDR, 16'h0000);
        wreg(`CBG_DIV_ADDR, 16'hFFFF);
        wreg(`CBG_SRC_ADDR, 16'hFFFF);
        wreg(8'h74, 16'h1234);
        rreg(`CBG_DIV_ADDR, 16'hFFFF);
        rreg(`CBG_SRC_ADDR, 16'h30F0);
        rreg(8'h74, 16'h0000);
        // Host sweeps filter and rate settings as a configuring host would
        for (k = 0; k < 8; k++) begin
            meas(16'(16'hE000 | (k % 4) << 11 | k << 8 | k << 3 | (7 - k)), 16'h0050, 1280);
            `CHK("filt", 1'b1, near(nf, 10240 / (ftab[k] * (k % 4 + 1))))
            `CHK("dec_rate", 1'b1, near(nd, 10240 / btab[k]))
            `CHK("enc_rate", 1'b1, near(ne, 10240 / btab[7 - k]))
        end
        for (k = 0; k < 4; k++) begin
            meas(16'(16'hE000 | k << 6), 16'h0050, 1280);
            `CHK("pre", 1'b1, near(nd, 1280 / (k + 1)))
            `CHK("bclk", 1'b1, near(rdc, 20 / (k + 1)))
        end
        meas(16'h60C0, 16'h0050, 1280);
        `CHK("bypass", 1'b1, near(nd, 1280))
        run = 1'b1;
        meas(16'h8000, 16'h0000, 1280);
        `CHK("dec_off", 0, nd + rdc)
        `CHK("enc_off", 0, ne + rec)
        meas(16'hE000, 16'h0020, 1280);
        `CHK("dec_pin", 1'b1, near(rdc, 80))
        `CHK("enc_pin", 1'b1, near(rec, 80))
        meas(16'hE008, 16'h0050, 1280);
        `CHK("dec_int", 1'b1, near(rdc, 10))
        `CHK("enc_int", 1'b1, near(rec, 20))
        meas(16'hE008, 16'h0070, 1280);
        `CHK("enc_dec", 1'b1, near(rec, 10))
        per = 8'd63;
        meas(16'hE000, 16'h0040, 6300);
        `CHK("free", 1'b1, near(rdc, 98))
        for (k = 0; k < 3; k++) begin
            meas(16'hE000, lsrc[k], 6300);
            `CHK("lock", 1'b1, near(rdc, 100))
        end
        conclude();
    end
endmodule
